// *** hw/sfwp_regs.svh ***
// constants for the flash write-protect and status block
// assumes a 10 MHz ref_clk; the instruction decoder supplies opcodes
`ifndef SFWP_REGS_SVH
`define SFWP_REGS_SVH

`define SFWP_CLK_MHZ        10
// status bit positions, low byte then high byte
`define SFWP_BIT_BUSY       0
`define SFWP_BIT_WEL        1
`define SFWP_BIT_BP_LO      2
`define SFWP_BIT_TB         5
`define SFWP_BIT_SEC        6
`define SFWP_BIT_SRP_LO     7
`define SFWP_BIT_SRP_UP     8
`define SFWP_BIT_QE         9
`define SFWP_BIT_LB_LO      11
`define SFWP_BIT_CMP        14
`define SFWP_BIT_SUS        15
// factory defaults of the non-volatile fields
`define SFWP_BP_RST         3'h0
`define SFWP_SRP_RST        2'h0
`define SFWP_LB_RST         3'h0
// instruction codes
`define SFWP_OP_WREN        8'h06
`define SFWP_OP_WRDI        8'h04
`define SFWP_OP_RDSR_LO     8'h05
`define SFWP_OP_RDSR_HI     8'h35
`define SFWP_OP_WRSR        8'h01
`define SFWP_OP_PP          8'h02
`define SFWP_OP_QPP         8'h32
`define SFWP_OP_SE          8'h20
`define SFWP_OP_BE32        8'h52
`define SFWP_OP_BE64        8'hD8
`define SFWP_OP_CE          8'hC7
`define SFWP_OP_SR_ERASE    8'h44
`define SFWP_OP_SR_PROG     8'h42
`define SFWP_OP_PD          8'hB9
`define SFWP_OP_RPD         8'hAB
`define SFWP_OP_SUSPEND     8'h75
`define SFWP_OP_RESUME      8'h7A
// array geometry, 19-bit byte address carried in 20 bits
`define SFWP_ARRAY_BYTES    20'h80000
`define SFWP_ARRAY_LAST     20'h7FFFF
`define SFWP_MASK_PAGE      20'h000FF
`define SFWP_MASK_4K        20'h00FFF
`define SFWP_MASK_32K       20'h07FFF
`define SFWP_MASK_64K       20'h0FFFF
// timing
`define SFWP_PU_DELAY_US    5000
`define SFWP_PU_CYCLES      (`SFWP_PU_DELAY_US * `SFWP_CLK_MHZ)
`define SFWP_SRWR_TIME_NS   10000
`define SFWP_SRWR_CYCLES    ((`SFWP_SRWR_TIME_NS * `SFWP_CLK_MHZ) / 1000)

`endif

// *** hw/sfwp_pkg.sv ***
// types shared by the write-protect and status block
// no assumptions beyond a SystemVerilog package
package sfwp_pkg;
  typedef enum logic [3:0] {
    SFWP_IDLE  = 4'b0001,
    SFWP_ARRAY = 4'b0010,
    SFWP_STWR  = 4'b0100,
    SFWP_SUSP  = 4'b1000
  } sfwp_state_e;
  typedef logic [19:0] sfwp_addr_t;
endpackage

// *** hw/sfwp_prot_range.sv ***
// protected address range decode and target overlap check
// purely combinational; the caller registers whatever it drives out
`timescale 1ns/1ps
`default_nettype none
`include "sfwp_regs.svh"

module sfwp_prot_range (
  input  wire logic               sector_block_select,
  input  wire logic               top_bottom_select,
  input  wire logic [2:0]         range_bits,
  input  wire logic               complement_protect,
  input  wire sfwp_pkg::sfwp_addr_t tgt_lo,
  input  wire sfwp_pkg::sfwp_addr_t tgt_hi,
  output logic                    hit
);

  // size of the shielded region in bytes, zero for none
  function automatic sfwp_pkg::sfwp_addr_t region_size(input logic sec, input logic [2:0] bp);
    sfwp_pkg::sfwp_addr_t s;
    s = 20'h00000;
    if (!sec) begin
      case (bp)
        3'h0:    s = 20'h00000;
        3'h1:    s = 20'h10000;
        3'h2:    s = 20'h20000;
        3'h3:    s = 20'h40000;
        default: s = `SFWP_ARRAY_BYTES;
      endcase
    end else begin
      case (bp)
        3'h0:    s = 20'h00000;
        3'h1:    s = 20'h01000;
        3'h2:    s = 20'h02000;
        3'h3:    s = 20'h04000;
        3'h7:    s = `SFWP_ARRAY_BYTES;
        default: s = 20'h08000;
      endcase
    end
    return s;
  endfunction

  sfwp_pkg::sfwp_addr_t size;
  sfwp_pkg::sfwp_addr_t lo;
  sfwp_pkg::sfwp_addr_t hi;
  logic                 any;

  always_comb begin
    size = region_size(sector_block_select, range_bits);
    any  = 1'b1;
    lo   = 20'h00000;
    hi   = `SFWP_ARRAY_LAST;
    if (size == 20'h00000) begin
      any = complement_protect;
    end else if (size == `SFWP_ARRAY_BYTES) begin
      any = !complement_protect;
    end else if (!top_bottom_select) begin
      // top region, complement keeps the bottom
      lo = complement_protect ? 20'h00000 : (`SFWP_ARRAY_BYTES - size);
      hi = complement_protect ? (`SFWP_ARRAY_BYTES - size - 20'h00001) : `SFWP_ARRAY_LAST;
    end else begin
      lo = complement_protect ? size : 20'h00000;
      hi = complement_protect ? `SFWP_ARRAY_LAST : (size - 20'h00001);
    end
    // any overlap at all refuses the whole operation
    hit = any && (tgt_lo <= hi) && (tgt_hi >= lo);
  end

endmodule
`default_nettype wire

// *** hw/sfwp_status_ctrl.sv ***
// write-protect and status-register control of a serial NOR flash
// assumes an instruction decoder on ref_clk and an array engine that pulses op_done
`timescale 1ns/1ps
`default_nettype none
`include "sfwp_regs.svh"

module sfwp_status_ctrl #(
  parameter int PU_WAIT_CYCLES = `SFWP_PU_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        supply_ok_pin,
  input  wire logic        write_protect_n_pin,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        cmd_byte_aligned,
  input  wire logic [18:0] cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        op_done,
  output logic [7:0]       status_low_byte,
  output logic [7:0]       status_high_byte,
  output logic             cmd_accept,
  output logic             cmd_ignored,
  output logic             array_start,
  output logic [7:0]       array_op_code,
  output logic             array_suspend,
  output logic             power_down_state,
  output logic             quad_data_mode,
  output logic             protect_pins_active
);

  function automatic logic is_array_op(input logic [7:0] c);
    return c == `SFWP_OP_PP || c == `SFWP_OP_QPP || c == `SFWP_OP_SE ||
           c == `SFWP_OP_BE32 || c == `SFWP_OP_BE64 || c == `SFWP_OP_CE;
  endfunction

  function automatic logic is_secreg_op(input logic [7:0] c);
    return c == `SFWP_OP_SR_ERASE || c == `SFWP_OP_SR_PROG;
  endfunction

  // three-stage pin synchronisers
  logic [2:0] supply_sync_reg;
  logic [2:0] wp_sync_reg;
  logic       supply_ok;
  logic       wp_high;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      supply_sync_reg <= 3'h0;
      wp_sync_reg     <= 3'h0;
      supply_ok       <= 1'b0;
      wp_high         <= 1'b0;
    end else begin
      supply_sync_reg <= {supply_sync_reg[1:0], supply_ok_pin};
      wp_sync_reg     <= {wp_sync_reg[1:0], write_protect_n_pin};
      if (supply_sync_reg[1] == supply_sync_reg[2]) begin
        supply_ok <= supply_sync_reg[2];
      end
      if (wp_sync_reg[1] == wp_sync_reg[2]) begin
        wp_high <= wp_sync_reg[2];
      end
    end
  end

  // power-up write delay, restarted by every supply loss
  logic [16:0] pu_cnt_reg;
  logic        pu_done;

  always_ff @(posedge ref_clk) begin
    if (reset || !supply_ok) begin
      pu_cnt_reg <= 17'h00000;
    end else if (!pu_done) begin
      pu_cnt_reg <= pu_cnt_reg + 17'h00001;
    end
  end
  assign pu_done = (pu_cnt_reg >= 17'(PU_WAIT_CYCLES));

  sfwp_pkg::sfwp_state_e state_reg;
  logic [15:0] srwr_cnt_reg;
  logic [15:0] sr_pend_reg;
  logic        wel_reg;
  logic        sus_reg;
  logic        pd_reg;
  logic [2:0]  bp_reg;
  logic        tb_reg;
  logic        sec_reg;
  logic        cmp_reg;
  logic        qe_reg;
  logic [1:0]  srp_reg;
  logic [2:0]  lb_reg;
  logic        busy;
  logic        srwr_end;

  assign busy     = (state_reg == sfwp_pkg::SFWP_ARRAY) || (state_reg == sfwp_pkg::SFWP_STWR);
  assign srwr_end = (state_reg == sfwp_pkg::SFWP_STWR) && (srwr_cnt_reg == 16'h0000);

  // target region of a program or erase
  sfwp_pkg::sfwp_addr_t tgt_mask;
  sfwp_pkg::sfwp_addr_t tgt_lo;
  sfwp_pkg::sfwp_addr_t tgt_hi;
  logic                 prot_hit;

  always_comb begin
    case (cmd_code)
      `SFWP_OP_SE:   tgt_mask = `SFWP_MASK_4K;
      `SFWP_OP_BE32: tgt_mask = `SFWP_MASK_32K;
      `SFWP_OP_BE64: tgt_mask = `SFWP_MASK_64K;
      `SFWP_OP_CE:   tgt_mask = `SFWP_ARRAY_LAST;
      default:       tgt_mask = `SFWP_MASK_PAGE;
    endcase
    tgt_lo = {1'b0, cmd_addr} & ~tgt_mask;
    tgt_hi = {1'b0, cmd_addr} | tgt_mask;
  end

  sfwp_prot_range u_range (
    .sector_block_select (sec_reg),
    .top_bottom_select   (tb_reg),
    .range_bits          (bp_reg),
    .complement_protect  (cmp_reg),
    .tgt_lo              (tgt_lo),
    .tgt_hi              (tgt_hi),
    .hit                 (prot_hit)
  );

  // admission of one decoded instruction
  logic is_arr;
  logic is_sec;
  logic is_wrsr;
  logic gated;
  logic sr_writable;
  logic lock_hit;
  logic accept_c;
  logic take;
  logic drop;

  always_comb begin
    is_arr  = is_array_op(cmd_code);
    is_sec  = is_secreg_op(cmd_code);
    is_wrsr = (cmd_code == `SFWP_OP_WRSR);
    gated   = is_arr || is_sec || is_wrsr;
    // pin counts only while it is still a protect pin
    case (srp_reg)
      2'b00:   sr_writable = 1'b1;
      2'b01:   sr_writable = wp_high || qe_reg;
      default: sr_writable = 1'b0;
    endcase
    case (cmd_addr[13:12])
      2'h1:    lock_hit = lb_reg[0];
      2'h2:    lock_hit = lb_reg[1];
      2'h3:    lock_hit = lb_reg[2];
      default: lock_hit = 1'b1;
    endcase
    accept_c = 1'b0;
    if (pd_reg) begin
      accept_c = (cmd_code == `SFWP_OP_RPD);
    end else if (busy) begin
      accept_c = cmd_code == `SFWP_OP_RDSR_LO || cmd_code == `SFWP_OP_RDSR_HI ||
                 (cmd_code == `SFWP_OP_SUSPEND && state_reg == sfwp_pkg::SFWP_ARRAY);
    end else if (state_reg == sfwp_pkg::SFWP_SUSP && gated) begin
      accept_c = 1'b0;
    end else if ((gated || cmd_code == `SFWP_OP_WREN) && !pu_done) begin
      accept_c = 1'b0;
    end else if (gated) begin
      accept_c = wel_reg && cmd_byte_aligned &&
                 !(is_arr && prot_hit) &&
                 !(cmd_code == `SFWP_OP_QPP && !qe_reg) &&
                 !(is_sec && lock_hit) &&
                 !(is_wrsr && !sr_writable);
    end else begin
      case (cmd_code)
        `SFWP_OP_WREN, `SFWP_OP_WRDI, `SFWP_OP_RDSR_LO,
        `SFWP_OP_RDSR_HI, `SFWP_OP_PD: accept_c = 1'b1;
        `SFWP_OP_RESUME: accept_c = (state_reg == sfwp_pkg::SFWP_SUSP);
        default:         accept_c = 1'b0;
      endcase
    end
    // nothing is recognised, not even as ignored, without supply
    take = cmd_valid && supply_ok && accept_c;
    drop = cmd_valid && supply_ok && !accept_c;
  end

  // busy sequencing
  always_ff @(posedge ref_clk) begin
    if (reset || !supply_ok) begin
      state_reg    <= sfwp_pkg::SFWP_IDLE;
      srwr_cnt_reg <= 16'h0000;
    end else begin
      case (state_reg)
        sfwp_pkg::SFWP_IDLE: begin
          if (take && (is_arr || is_sec)) begin
            state_reg <= sfwp_pkg::SFWP_ARRAY;
          end else if (take && is_wrsr) begin
            state_reg    <= sfwp_pkg::SFWP_STWR;
            srwr_cnt_reg <= 16'(`SFWP_SRWR_CYCLES - 1);
          end
        end
        sfwp_pkg::SFWP_ARRAY: begin
          if (take && cmd_code == `SFWP_OP_SUSPEND) begin
            state_reg <= sfwp_pkg::SFWP_SUSP;
          end else if (op_done) begin
            state_reg <= sfwp_pkg::SFWP_IDLE;
          end
        end
        sfwp_pkg::SFWP_STWR: begin
          if (srwr_end) begin
            state_reg <= sfwp_pkg::SFWP_IDLE;
          end else begin
            srwr_cnt_reg <= srwr_cnt_reg - 16'h0001;
          end
        end
        sfwp_pkg::SFWP_SUSP: begin
          if (take && cmd_code == `SFWP_OP_RESUME) begin
            state_reg <= sfwp_pkg::SFWP_ARRAY;
          end
        end
        default: state_reg <= sfwp_pkg::SFWP_IDLE;
      endcase
    end
  end

  // volatile flags, lost with the supply
  always_ff @(posedge ref_clk) begin
    if (reset || !supply_ok) begin
      wel_reg <= 1'b0;
      sus_reg <= 1'b0;
      pd_reg  <= 1'b0;
    end else begin
      if (take && cmd_code == `SFWP_OP_WREN) begin
        wel_reg <= 1'b1;
      end else if ((take && cmd_code == `SFWP_OP_WRDI) || srwr_end ||
                   (state_reg == sfwp_pkg::SFWP_ARRAY && op_done)) begin
        wel_reg <= 1'b0;
      end
      if (take && cmd_code == `SFWP_OP_SUSPEND) begin
        sus_reg <= 1'b1;
      end else if (take && cmd_code == `SFWP_OP_RESUME) begin
        sus_reg <= 1'b0;
      end
      if (take && cmd_code == `SFWP_OP_PD) begin
        pd_reg <= 1'b1;
      end else if (take && cmd_code == `SFWP_OP_RPD) begin
        pd_reg <= 1'b0;
      end
    end
  end

  // non-volatile fields: reset stands for the factory state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sr_pend_reg <= 16'h0000;
      bp_reg      <= `SFWP_BP_RST;
      tb_reg      <= 1'b0;
      sec_reg     <= 1'b0;
      cmp_reg     <= 1'b0;
      qe_reg      <= 1'b0;
      srp_reg     <= `SFWP_SRP_RST;
      lb_reg      <= `SFWP_LB_RST;
    end else if (!supply_ok) begin
      if (srp_reg == 2'b10) begin
        srp_reg <= 2'b00;
      end
    end else begin
      if (take && is_wrsr) begin
        sr_pend_reg <= cmd_wdata;
      end
      // fields change only when the write cycle completes
      if (srwr_end) begin
        bp_reg  <= sr_pend_reg[`SFWP_BIT_BP_LO +: 3];
        tb_reg  <= sr_pend_reg[`SFWP_BIT_TB];
        sec_reg <= sr_pend_reg[`SFWP_BIT_SEC];
        cmp_reg <= sr_pend_reg[`SFWP_BIT_CMP];
        qe_reg  <= sr_pend_reg[`SFWP_BIT_QE];
        srp_reg <= {sr_pend_reg[`SFWP_BIT_SRP_UP], sr_pend_reg[`SFWP_BIT_SRP_LO]};
        lb_reg  <= lb_reg | sr_pend_reg[`SFWP_BIT_LB_LO +: 3];
      end
    end
  end

  // registered outputs, status shows one cycle after the state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_low_byte     <= 8'h00;
      status_high_byte    <= 8'h00;
      cmd_accept          <= 1'b0;
      cmd_ignored         <= 1'b0;
      array_start         <= 1'b0;
      array_op_code       <= 8'h00;
      array_suspend       <= 1'b0;
      power_down_state    <= 1'b0;
      quad_data_mode      <= 1'b0;
      protect_pins_active <= 1'b1;
    end else begin
      status_low_byte     <= {srp_reg[0], sec_reg, tb_reg, bp_reg, wel_reg, busy};
      status_high_byte    <= {sus_reg, cmp_reg, lb_reg, 1'b0, qe_reg, srp_reg[1]};
      cmd_accept          <= take;
      cmd_ignored         <= drop;
      array_start         <= take && (is_arr || is_sec) && state_reg == sfwp_pkg::SFWP_IDLE;
      if (take && (is_arr || is_sec)) begin
        array_op_code <= cmd_code;
      end
      array_suspend       <= (state_reg == sfwp_pkg::SFWP_SUSP);
      power_down_state    <= pd_reg;
      quad_data_mode      <= qe_reg;
      protect_pins_active <= !qe_reg;
    end
  end

  supply_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
    !supply_ok |=> !cmd_accept && !cmd_ignored) else $error("instruction seen without supply");
  pu_block_a: assert property (@(posedge ref_clk) disable iff (reset)
    cmd_valid && !pu_done && cmd_code == `SFWP_OP_WREN |=> !cmd_accept)
    else $error("write enable taken during power-up delay");
  wel_needed_a: assert property (@(posedge ref_clk) disable iff (reset)
    cmd_valid && gated && !wel_reg |=> !cmd_accept) else $error("write taken without latch");
  wel_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    srwr_end |=> !wel_reg ##1 !status_low_byte[`SFWP_BIT_WEL])
    else $error("latch kept after status write");
  pd_ignore_a: assert property (@(posedge ref_clk) disable iff (reset)
    supply_ok && pd_reg && cmd_valid && cmd_code != `SFWP_OP_RPD |=> !cmd_accept ##1 power_down_state)
    else $error("instruction taken in power-down");
  busy_ignore_a: assert property (@(posedge ref_clk) disable iff (reset)
    supply_ok && busy && cmd_valid && cmd_code == `SFWP_OP_WREN |=> cmd_ignored && !cmd_accept)
    else $error("instruction taken while busy");
  wp_lock_a: assert property (@(posedge ref_clk) disable iff (reset)
    srp_reg == 2'b01 && !wp_high && !qe_reg && cmd_valid && is_wrsr |=> !cmd_accept)
    else $error("status written with protect pin low");
  srp_cycle_a: assert property (@(posedge ref_clk) disable iff (reset)
    !supply_ok && srp_reg == 2'b10 |=> srp_reg == 2'b00) else $error("lock-down survived");
  otp_lock_a: assert property (@(posedge ref_clk) disable iff (reset)
    srp_reg == 2'b11 && cmd_valid && is_wrsr |=> !cmd_accept) else $error("otp status written");
  lb_sticky_a: assert property (@(posedge ref_clk) disable iff (reset)
    lb_reg != 3'h0 |=> (lb_reg & $past(lb_reg)) == $past(lb_reg)) else $error("lock bit cleared");
  prot_hit_a: assert property (@(posedge ref_clk) disable iff (reset)
    cmd_valid && is_arr && prot_hit |=> !cmd_accept && !array_start)
    else $error("protected region programmed");
  sus_set_a: assert property (@(posedge ref_clk) disable iff (reset)
    take && cmd_code == `SFWP_OP_SUSPEND |=> sus_reg ##1 status_high_byte[7])
    else $error("suspend flag not set");

endmodule
`default_nettype wire

// *** tb/sfwp_host_model.sv ***
// host controller and array engine model facing sfwp_status_ctrl
// assumes ref_clk drives both; instructions arrive already decoded
`timescale 1ns/1ps
`default_nettype none

module sfwp_host_model (
  input  wire logic        ref_clk,
  input  wire logic        array_start,
  input  wire logic        array_suspend,
  input  wire logic        cmd_accept,
  input  wire logic        cmd_ignored,
  output logic             cmd_valid,
  output logic [7:0]       cmd_code,
  output logic             cmd_byte_aligned,
  output logic [18:0]      cmd_addr,
  output logic [15:0]      cmd_wdata,
  output logic             op_done
);
  int done_delay = 30;
  int left       = 0;

  initial begin
    cmd_valid        = 1'b0;
    cmd_code         = 8'h00;
    cmd_byte_aligned = 1'b1;
    cmd_addr         = 19'h00000;
    cmd_wdata        = 16'h0000;
    op_done          = 1'b0;
  end

  // engine clock stops while held, so a suspended job never finishes
  always @(posedge ref_clk) begin
    op_done <= 1'b0;
    if (array_start) begin
      left <= done_delay;
    end else if (left > 0 && !array_suspend) begin
      left <= left - 1;
      op_done <= (left == 1);
    end
  end

  // one decoded instruction; lines show the inverse once released
  task automatic issue(input logic [7:0] code, input logic [18:0] addr, input logic [15:0] wd,
                       input logic al, output logic [1:0] ans);
    @(posedge ref_clk);
    #1;
    cmd_valid        = 1'b1;
    cmd_code         = code;
    cmd_addr         = addr;
    cmd_wdata        = wd;
    cmd_byte_aligned = al;
    @(posedge ref_clk);
    #1;
    cmd_valid        = 1'b0;
    cmd_code         = ~code;
    cmd_addr         = ~addr;
    cmd_wdata        = ~wd;
    cmd_byte_aligned = ~al;
    ans              = {cmd_accept, cmd_ignored};
  endtask
endmodule

`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for sfwp_status_ctrl
// assumes the host model file; short power-up wait of 20 cycles
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [1:0] ACC  = 2'b10;
  localparam logic [1:0] IGN  = 2'b01;
  localparam logic [1:0] NONE = 2'b00;

  logic        ref_clk             = 1'b0;
  logic        reset               = 1'b1;
  logic        supply_ok_pin       = 1'b0;
  logic        write_protect_n_pin = 1'b1;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic        cmd_byte_aligned;
  logic [18:0] cmd_addr;
  logic [15:0] cmd_wdata;
  logic        op_done;
  logic [7:0]  status_low_byte;
  logic [7:0]  status_high_byte;
  logic        cmd_accept;
  logic        cmd_ignored;
  logic        array_start;
  logic        array_suspend;
  logic [7:0]  array_op_code;
  logic        power_down_state;
  logic        quad_data_mode;
  logic        protect_pins_active;
  logic [15:0] sr;
  int          n_mismatch = 0;
  int          tests_run  = 0;

  assign sr = {status_high_byte, status_low_byte};

  always #50 ref_clk = ~ref_clk;

  sfwp_status_ctrl #(.PU_WAIT_CYCLES(20)) dut (
    .ref_clk(ref_clk), .reset(reset), .supply_ok_pin(supply_ok_pin),
    .write_protect_n_pin(write_protect_n_pin), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_byte_aligned(cmd_byte_aligned), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .op_done(op_done), .status_low_byte(status_low_byte),
    .status_high_byte(status_high_byte), .cmd_accept(cmd_accept),
    .cmd_ignored(cmd_ignored), .array_start(array_start), .array_op_code(array_op_code),
    .array_suspend(array_suspend), .power_down_state(power_down_state),
    .quad_data_mode(quad_data_mode), .protect_pins_active(protect_pins_active));

  sfwp_host_model host (
    .ref_clk(ref_clk), .array_start(array_start), .array_suspend(array_suspend),
    .cmd_accept(cmd_accept), .cmd_ignored(cmd_ignored), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_byte_aligned(cmd_byte_aligned), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .op_done(op_done));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic cmd(input logic [7:0] code, input logic [18:0] addr, input logic [15:0] wd,
                     input logic al, input logic [1:0] exp);
    logic [1:0] ans;
    host.issue(code, addr, wd, al, ans);
    check({14'h0000, ans}, {14'h0000, exp}, "answer");
  endtask

  task automatic wait_idle();
    int i;
    step(2);
    for (i = 0; i < 2000 && sr[0] !== 1'b0; i++) step(1);
    if (i == 2000) begin
      n_mismatch++;
      $display("mismatch at %0t: busy never cleared", $time);
      report_and_stop();
    end
  endtask

  task automatic wrsr(input logic [15:0] wd);
    cmd(8'h06, 19'h00000, 16'h0000, 1'b1, ACC);
    cmd(8'h01, 19'h00000, wd, 1'b1, ACC);
    step(1);
    check(sr & 16'h0001, 16'h0001, "busy");
    wait_idle();
    check(sr & 16'h0003, 16'h0000, "wel and busy");
  endtask

  task automatic prog(input logic [18:0] addr, input logic al, input logic [1:0] exp);
    cmd(8'h06, 19'h00000, 16'h0000, 1'b1, ACC);
    cmd(8'h02, addr, 16'h0000, al, exp);
    if (exp == ACC) wait_idle();
    else cmd(8'h04, 19'h00000, 16'h0000, 1'b1, ACC);
  endtask

  task automatic supply_cycle();
    supply_ok_pin = 1'b0;
    step(8);
    supply_ok_pin = 1'b1;
    step(30);
  endtask

  task automatic t_power_up();
    cmd(8'h05, 19'h00000, 16'h0000, 1'b1, NONE);
    cmd(8'h06, 19'h00000, 16'h0000, 1'b1, NONE);
    supply_ok_pin = 1'b1;
    step(6);
    cmd(8'h06, 19'h00000, 16'h0000, 1'b1, IGN);
    cmd(8'h05, 19'h00000, 16'h0000, 1'b1, ACC);
    step(30);
    cmd(8'h02, 19'h00000, 16'h0000, 1'b1, IGN);
    cmd(8'h06, 19'h00000, 16'h0000, 1'b1, ACC);
    step(2);
    check(sr & 16'h0002, 16'h0002, "wel set");
    cmd(8'h04, 19'h00000, 16'h0000, 1'b1, ACC);
    step(2);
    check(sr, 16'h0000, "factory status");
    prog(19'h00100, 1'b0, IGN);
    cmd(8'h06, 19'h00000, 16'h0000, 1'b1, ACC);
    cmd(8'h32, 19'h00100, 16'h0000, 1'b1, IGN);
    cmd(8'h04, 19'h00000, 16'h0000, 1'b1, ACC);
    $display("t_power_up done");
  endtask

  task automatic t_ranges();
    wrsr(16'h0204);
    check(sr, 16'h0204, "range and quad");
    check({14'h0000, quad_data_mode, protect_pins_active}, 16'h0002, "quad pins");
    prog(19'h70000, 1'b1, IGN);
    prog(19'h6FF00, 1'b1, ACC);
    wrsr(16'h4204);
    prog(19'h70000, 1'b1, ACC);
    prog(19'h00000, 1'b1, IGN);
    wrsr(16'h0264);
    prog(19'h00F00, 1'b1, IGN);
    prog(19'h01000, 1'b1, ACC);
    cmd(8'h06, 19'h00000, 16'h0000, 1'b1, ACC);
    cmd(8'hD8, 19'h08000, 16'h0000, 1'b1, IGN);
    cmd(8'hC7, 19'h00000, 16'h0000, 1'b1, IGN);
    cmd(8'h20, 19'h01000, 16'h0000, 1'b1, ACC);
    check({8'h00, array_op_code}, 16'h0020, "engine opcode");
    wait_idle();
    $display("t_ranges done");
  endtask

  task automatic t_suspend();
    cmd(8'h06, 19'h00000, 16'h0000, 1'b1, ACC);
    cmd(8'h02, 19'h40000, 16'h0000, 1'b1, ACC);
    cmd(8'h06, 19'h00000, 16'h0000, 1'b1, IGN);
    cmd(8'h05, 19'h00000, 16'h0000, 1'b1, ACC);
    cmd(8'h75, 19'h00000, 16'h0000, 1'b1, ACC);
    step(2);
    check(sr & 16'h8001, 16'h8000, "suspended");
    step(40);
    check({15'h0000, array_suspend}, 16'h0001, "engine held");
    cmd(8'h7A, 19'h00000, 16'h0000, 1'b1, ACC);
    step(2);
    check(sr & 16'h8001, 16'h0001, "resumed");
    wait_idle();
    check(sr & 16'h0002, 16'h0000, "wel after program");
    $display("t_suspend done");
  endtask

  task automatic t_status_lock();
    wrsr(16'h0080);
    write_protect_n_pin = 1'b0;
    // pin needs four edges through the synchroniser
    step(5);
    cmd(8'h06, 19'h00000, 16'h0000, 1'b1, ACC);
    cmd(8'h01, 19'h00000, 16'h0000, 1'b1, IGN);
    write_protect_n_pin = 1'b1;
    step(5);
    cmd(8'h01, 19'h00000, 16'h0100, 1'b1, ACC);
    wait_idle();
    cmd(8'h06, 19'h00000, 16'h0000, 1'b1, ACC);
    cmd(8'h01, 19'h00000, 16'h0000, 1'b1, IGN);
    supply_cycle();
    check(sr & 16'h0182, 16'h0000, "lock-down lifted");
    write_protect_n_pin = 1'b0;
    step(5);
    wrsr(16'h0800);
    cmd(8'h06, 19'h00000, 16'h0000, 1'b1, ACC);
    cmd(8'h44, 19'h01000, 16'h0000, 1'b1, IGN);
    cmd(8'h04, 19'h00000, 16'h0000, 1'b1, ACC);
    cmd(8'h06, 19'h00000, 16'h0000, 1'b1, ACC);
    cmd(8'h42, 19'h02000, 16'h0000, 1'b1, ACC);
    wait_idle();
    wrsr(16'h0000);
    check(sr & 16'h3800, 16'h0800, "lock stays set");
    $display("t_status_lock done");
  endtask

  task automatic t_power_down_otp();
    cmd(8'hB9, 19'h00000, 16'h0000, 1'b1, ACC);
    step(1);
    check({15'h0000, power_down_state}, 16'h0001, "power-down entered");
    cmd(8'h05, 19'h00000, 16'h0000, 1'b1, IGN);
    cmd(8'hAB, 19'h00000, 16'h0000, 1'b1, ACC);
    step(1);
    check({15'h0000, power_down_state}, 16'h0000, "power-down left");
    wrsr(16'h0180);
    supply_cycle();
    cmd(8'h06, 19'h00000, 16'h0000, 1'b1, ACC);
    cmd(8'h01, 19'h00000, 16'h0000, 1'b1, IGN);
    check(sr & 16'h0180, 16'h0180, "otp protect");
    $display("t_power_down_otp done");
  endtask

  initial begin
    step(12);
    reset = 1'b0;
    t_power_up();
    t_ranges();
    t_suspend();
    t_status_lock();
    t_power_down_otp();
    report_and_stop();
  end
endmodule

`default_nettype wire
